// ---- qbpb_core_model.sv ----
// Core timing model: oscillator ticks and the machine cycle mark.
// Assumes the bank counts twelve ticks per machine cycle on its own.
`timescale 1ns/1ns
module qbpb_core_model
  import qbpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  output logic osc_tick,
  output logic cycle_mark
);
  logic [4:0] div;
  // One tick every second clock; mark on the first of twelve ticks
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      div <= 5'h00;
      osc_tick <= 1'b0;
      cycle_mark <= 1'b0;
    end
    else
    begin
      div <= (div == 5'h17) ? 5'h00 : div + 5'h01;
      osc_tick <= div[0];
      cycle_mark <= (div == 5'h01);
    end
endmodule

// ---- qbpb_monitor.sv ----
// Checker for the port bank: sees the top ports only.
// Assumes oscillator ticks come at most every second clock.
`timescale 1ns/1ns
module qbpb_monitor
  import qbpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic osc_tick,
  input wire logic cycle_mark,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_access,
  input wire logic ext_addr16,
  input wire logic ext_low_drive,
  input wire logic [7:0] muxed_low_bus_out,
  input wire logic [7:0] high_address_bus,
  input wire logic [7:0] muxed_low_bus_in,
  input wire logic serial_tx_out,
  input wire logic write_strobe_n,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] strong_pullup,
  input wire logic [31:0] keeper_pullup,
  input wire logic [31:0] weak_pullup
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [1:0] sp_ticks;
  // Ticks seen while the extra pullup is on; saturates so it never wraps
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      sp_ticks <= 2'h0;
    else if (!(|strong_pullup))
      sp_ticks <= 2'h0;
    else if (osc_tick && sp_ticks != 2'h3)
      sp_ticks <= sp_ticks + 2'h1;
  rd_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not zero while idle");
  pin_read_a: assert property (
    reg_rd && reg_addr == ADDR_PIN_BASE |=> reg_rdata == $past(muxed_low_bus_in))
    else $error("pin read does not return port zero pins");
  low_bus_a: assert property (
    ext_access && ext_low_drive |=> pin_oe_n[7:0] == 8'h00
      && pin_out[7:0] == $past(muxed_low_bus_out)) else $error("port zero not on bus");
  high_bus_a: assert property (
    ext_access && ext_addr16 |=> pin_oe_n[23:16] == 8'h00
      && pin_out[23:16] == $past(high_address_bus)) else $error("port two not on bus");
  p0_pullup_a: assert property (
    (strong_pullup[7:0] | keeper_pullup[7:0] | weak_pullup[7:0]) == 8'h00)
    else $error("port zero pullup on");
  p0_drain_a: assert property (
    !ext_access |=> pin_out[7:0] == 8'h00) else $error("port zero drives high");
  alt_tx_a: assert property (
    !serial_tx_out |=> !pin_oe_n[25]) else $error("serial out low not driven");
  alt_wr_a: assert property (
    !write_strobe_n |=> !pin_oe_n[30]) else $error("write strobe low not driven");
  buf_slot_a: assert property (
    $changed(pin_oe_n[23:16]) && !$past(ext_access) && !$past(ext_access, 2)
      |-> $past(osc_tick, 2)) else $error("port two pins changed off a phase");
  sp_start_a: assert property (
    $rose(|strong_pullup) |-> $past(cycle_mark) || $past(cycle_mark, 2))
    else $error("extra pullup not at state one");
  sp_long_a: assert property (
    (|strong_pullup) && osc_tick |-> sp_ticks < 2'h2) else $error("extra pullup too long");
  sp_short_a: assert property (
    $fell(|strong_pullup) |-> sp_ticks == 2'h2) else $error("extra pullup too short");
  weak_pull_a: assert property (
    !$past(ext_access) |-> weak_pullup[31:8] == pin_oe_n[31:8])
    else $error("very weak pullup not tracking pull-down off");
endmodule

bind qbpb_top qbpb_monitor mon (.*);

// ---- qbpb_pkg.sv ----
// Package for the quasi-bidirectional port bank: address map, reset values,
// machine-cycle phase numbering and alternate function bit positions.
// Assumes one 50 MHz system clock; oscillator periods arrive as tick pulses.
package qbpb_pkg;

  // Register port address map
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_LATCH_BASE = 4'h0;
  localparam logic [3:0] ADDR_PIN_BASE = 4'h4;
  localparam logic [3:0] ADDR_BIT_BASE = 4'h8;
  localparam logic [1:0] ADDR_GROUP_LATCH = 2'h0;
  localparam logic [1:0] ADDR_GROUP_PIN = 2'h1;
  localparam logic [1:0] ADDR_GROUP_BIT = 2'h2;

  // Bit operation write data layout
  localparam int BITOP_VALUE_POS = 3;
  localparam int BITOP_INDEX_POS = 0;

  // Reset values
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [31:0] BANK_RESET = 32'hFFFFFFFF;

  // Machine cycle: six states of two phases, one phase per oscillator period
  localparam int PHASE_COUNT = 12;
  localparam logic [3:0] PH_STATE1_PHASE1 = 4'h0;
  localparam logic [3:0] PH_STATE1_PHASE2 = 4'h1;
  localparam logic [3:0] PH_STATE6_PHASE2 = 4'hB;
  localparam logic [3:0] PH_LAST = 4'hB;

  // Extra pullup lasts this many oscillator periods after a 0-to-1 change
  localparam int STRONG_PULLUP_PERIODS = 2;

  // Pin input synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Port one alternate functions
  localparam int P1_TIMER_TWO_CLOCK = 0;
  localparam int P1_TIMER_TWO_RELOAD = 1;
  localparam int P1_ARRAY_CLOCK = 2;
  localparam int P1_ARRAY_MODULE0 = 3;

  // Port three alternate functions
  localparam int P3_SERIAL_IN = 0;
  localparam int P3_SERIAL_OUT = 1;
  localparam int P3_IRQ_ZERO = 2;
  localparam int P3_IRQ_ONE = 3;
  localparam int P3_TIMER_ZERO = 4;
  localparam int P3_TIMER_ONE = 5;
  localparam int P3_WRITE_STROBE = 6;
  localparam int P3_READ_STROBE = 7;

endpackage

// ---- qbpb_sync.sv ----
// Pin input synchroniser for the port bank: three shift flip-flops and one output flip-flop per bit.
// A change is accepted only when the second and third stages agree.
`timescale 1ns/1ns
module qbpb_sync
  import qbpb_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain; stage1 is only read by stage2
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept per bit once two late stages agree, so a glitch costs a cycle, not a value
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
          sync_out[i] <= 1'b1;
        else if (stage2[i] == stage3[i])
          sync_out[i] <= stage3[i];
      end
    end
  endgenerate

endmodule

// ---- qbpb_top.sv ----
// Quasi-bidirectional port bank: four eight-bit ports with latches, output
// buffers, pullup control, external bus override and alternate functions.
// Assumes the core supplies oscillator ticks and a state-one-phase-one mark.
// Operation
// - Write request loads latch; read-latch returns latch; read-pin returns synced pin.
// - During external access, port zero drives bus values instead of its latch while ext_low_drive; port two only while ext_addr16.
// - External access leaves port two latch alone, forces port zero latch to ones.
// - Port one/three latch one lets the alternate output steer the pin.
// - Synced pin level always goes to the alternate input function.
// - Port one bits map to timer two, array clock and array modules.
// - Port three bits map to serial, interrupts, timer inputs, memory strobes.
// - Port zero carries muxed low address/data, port two high address byte.
// - Port zero has no pullup at all; push-pull while ext_low_drive, floats in other bus cycles, else open drain.
// - Reset loads ones into all latches; rewriting one restores input use.
// - Written value reaches the latch at state six phase two.
// - Buffers sample latches in phase one only, holding through phase two.
// - Latch zero-to-one on ports one to three gives strong pullup two periods.
// - Keeper pullup while pin reads one; very weak pullup while pull-down off.
// - Read-modify-write operations read the latch, not the pin.
// - Bit set/clear/move reads all latch bits, changes one, writes byte back.
// - Plain port reads use the pin path.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module qbpb_top
  import qbpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  // Machine cycle timing
  input wire logic osc_tick,
  input wire logic cycle_mark,
  // Core register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External memory control
  input wire logic ext_access,
  input wire logic ext_addr16,
  input wire logic ext_low_drive,
  input wire logic [7:0] muxed_low_bus_out,
  input wire logic [7:0] high_address_bus,
  output logic [7:0] muxed_low_bus_in,
  // Alternate outputs
  input wire logic timer_two_clock_out,
  input wire logic [4:0] array_module_out,
  input wire logic serial_tx_out,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  // Alternate inputs
  output logic timer_two_clock_io,
  output logic timer_two_reload_capture_in,
  output logic array_external_clock,
  output logic [4:0] array_module_pin,
  output logic serial_rx_in,
  output logic external_irq_zero,
  output logic external_irq_one,
  output logic timer_zero_count_in,
  output logic timer_one_count_in,
  // Pads, port n at bits 8n+7 .. 8n
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_n,
  output logic [31:0] strong_pullup,
  output logic [31:0] keeper_pullup,
  output logic [31:0] weak_pullup
);

  logic [3:0] phase;
  logic [3:0] cur_phase;
  logic [3:0] next_phase;
  logic [31:0] latches;
  logic [31:0] out_buf;
  logic [31:0] pin_sync;
  logic pend_valid;
  logic [1:0] pend_port;
  logic [7:0] pend_data;
  logic [1:0] acc_port;
  logic [1:0] acc_group;
  logic [7:0] rmw_base;
  logic [7:0] rmw_byte;
  logic [2:0] bit_index;
  logic commit;
  logic sample;
  logic wr_latch;
  logic wr_bit;
  logic [7:0] alt_one;
  logic [7:0] alt_three;
  logic [31:0] drive_val;
  logic [31:0] rise;

  assign acc_group = reg_addr[3:2];
  assign acc_port = reg_addr[1:0];
  assign wr_latch = reg_wr && (acc_group == ADDR_GROUP_LATCH);
  assign wr_bit = reg_wr && (acc_group == ADDR_GROUP_BIT);

  // Phase of the current tick; cycle_mark realigns to state one phase one
  always_comb
  begin
    if (cycle_mark)
      cur_phase = PH_STATE1_PHASE1;
    else if (phase == PH_LAST)
      cur_phase = PH_STATE1_PHASE1;
    else
      cur_phase = phase + 4'h1;
  end

  assign next_phase = osc_tick ? cur_phase : phase;

  // Phase counter holds the phase of the last tick; starts as if at STATE6_PHASE2
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      phase <= PH_LAST;
    else
      phase <= next_phase;
  end

  // Latch commits at STATE6_PHASE2, buffers sample on every phase one
  assign commit = osc_tick && (cur_phase == PH_STATE6_PHASE2);
  assign sample = osc_tick && !cur_phase[0];

  // Bit operation base: all eight latch bits, newest pending value first
  assign bit_index = reg_wdata[BITOP_INDEX_POS +: 3];
  always_comb
  begin
    if (pend_valid && (pend_port == acc_port))
      rmw_base = pend_data;
    else
      rmw_base = latches[{acc_port, 3'b000} +: 8];
    rmw_byte = rmw_base;
    rmw_byte[bit_index] = reg_wdata[BITOP_VALUE_POS];
  end

  // Pending write waits for STATE6_PHASE2; a write in the commit cycle stays pending
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_valid <= 1'b0;
      pend_port <= 2'h0;
      pend_data <= LATCH_RESET;
    end
    else if (wr_latch || wr_bit)
    begin
      pend_valid <= 1'b1;
      pend_port <= acc_port;
      pend_data <= wr_bit ? rmw_byte : reg_wdata;
    end
    else if (commit)
      pend_valid <= 1'b0;
  end

  // Port latches; external access overwrites port zero with ones only
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      latches <= BANK_RESET;
    else
    begin
      if (commit && pend_valid)
        latches[{pend_port, 3'b000} +: 8] <= pend_data;
      if (ext_access)
        latches[7:0] <= LATCH_RESET;
    end
  end

  // Output buffers track latches in phase one, hold through phase two
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      out_buf <= BANK_RESET;
    else if (sample)
      out_buf <= latches;
  end

  // Zero-to-one as seen by the buffer at STATE1_PHASE1; ports one to three only
  assign rise = {latches[31:8] & ~out_buf[31:8], 8'h00};

  // Strong pullup on at STATE1_PHASE1, off after the second period (S1P2 ends)
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      strong_pullup <= 32'h00000000;
    else if (osc_tick && (cur_phase == PH_STATE1_PHASE1))
      strong_pullup <= rise;
    else if (osc_tick && (cur_phase == PH_STATE1_PHASE2 + 4'h1))
      strong_pullup <= 32'h00000000;
  end

  // Register read: latch path for read-modify-write, pin path for the pin group, zero otherwise
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (acc_group)
        ADDR_GROUP_LATCH: reg_rdata <= latches[{acc_port, 3'b000} +: 8];
        ADDR_GROUP_PIN: reg_rdata <= pin_sync[{acc_port, 3'b000} +: 8];
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // Alternate outputs; unused positions idle high so the latch alone decides
  always_comb
  begin
    alt_one = 8'hFF;
    alt_one[P1_TIMER_TWO_CLOCK] = timer_two_clock_out;
    alt_one[P1_ARRAY_MODULE0 +: 5] = array_module_out;
    alt_three = 8'hFF;
    alt_three[P3_SERIAL_OUT] = serial_tx_out;
    alt_three[P3_WRITE_STROBE] = write_strobe_n;
    alt_three[P3_READ_STROBE] = read_strobe_n;
  end

  // Value each pin should show; bus override on ports zero and two
  always_comb
  begin
    drive_val[7:0] = ext_access ? muxed_low_bus_out : out_buf[7:0];
    drive_val[15:8] = out_buf[15:8] & alt_one;
    drive_val[23:16] = (ext_access && ext_addr16) ? high_address_bus : out_buf[23:16];
    drive_val[31:24] = out_buf[31:24] & alt_three;
  end

  // Per-pin drivers; a one turns the pull-down off so the pin can be an input
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_pin
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          pin_out[i] <= 1'b0;
          pin_oe_n[i] <= 1'b1;
          weak_pullup[i] <= (i >= 8); // Pull-down starts off on all ports; very weak pullup on ports one to three
          keeper_pullup[i] <= 1'b0;
        end
        else if (i < 8)
        begin
          // Open drain, push-pull only while the bus drives
          if (ext_access && ext_low_drive)
          begin
            pin_out[i] <= drive_val[i];
            pin_oe_n[i] <= 1'b0;
          end
          else if (ext_access)
          begin
            pin_out[i] <= 1'b0;
            pin_oe_n[i] <= 1'b1;
          end
          else
          begin
            pin_out[i] <= 1'b0;
            pin_oe_n[i] <= drive_val[i];
          end
          weak_pullup[i] <= 1'b0;
          keeper_pullup[i] <= 1'b0;
        end
        else
        begin
          // High address bits are driven hard while the bus owns port two
          if ((i >= 16) && (i < 24) && ext_access && ext_addr16)
          begin
            pin_out[i] <= drive_val[i];
            pin_oe_n[i] <= 1'b0;
          end
          else
          begin
            pin_out[i] <= 1'b0;
            pin_oe_n[i] <= drive_val[i];
          end
          weak_pullup[i] <= drive_val[i];
          keeper_pullup[i] <= pin_sync[i];
        end
      end
    end
  endgenerate

  // Pin levels, synchronised; also the read-pin path
  qbpb_sync #(
    .WIDTH(32)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // Alternate inputs see the real pin whatever the latch holds
  assign muxed_low_bus_in = pin_sync[7:0];
  assign timer_two_clock_io = pin_sync[8 + P1_TIMER_TWO_CLOCK];
  assign timer_two_reload_capture_in = pin_sync[8 + P1_TIMER_TWO_RELOAD];
  assign array_external_clock = pin_sync[8 + P1_ARRAY_CLOCK];
  assign array_module_pin = pin_sync[8 + P1_ARRAY_MODULE0 +: 5];
  assign serial_rx_in = pin_sync[24 + P3_SERIAL_IN];
  assign external_irq_zero = pin_sync[24 + P3_IRQ_ZERO];
  assign external_irq_one = pin_sync[24 + P3_IRQ_ONE];
  assign timer_zero_count_in = pin_sync[24 + P3_TIMER_ZERO];
  assign timer_one_count_in = pin_sync[24 + P3_TIMER_ONE];

endmodule

// ---- testbench.sv ----
// Self-checking bench for the port bank: latch traffic, pins, bus mode.
// Assumes pads resolved here from the drivers and an outside source.
`timescale 1ns/1ns
module testbench;
  import qbpb_pkg::*;
  logic clk_sys, resetn, osc_tick, cycle_mark, reg_wr, reg_rd, ext_access, ext_addr16;
  logic ext_low_drive, timer_two_clock_out, serial_tx_out, write_strobe_n, read_strobe_n;
  logic timer_two_clock_io, timer_two_reload_capture_in, array_external_clock, serial_rx_in;
  logic external_irq_zero, external_irq_one, timer_zero_count_in, timer_one_count_in, flt;
  logic rd_d, s;
  logic [2:0] b;
  logic [3:0] reg_addr;
  logic [4:0] array_module_out, array_module_pin;
  logic [7:0] reg_wdata, reg_rdata, muxed_low_bus_out, high_address_bus, muxed_low_bus_in;
  logic [7:0] v, lo, hi, exp_q[$];
  logic [31:0] pin_in, pin_out, pin_oe_n, strong_pullup, keeper_pullup, weak_pullup;
  logic [31:0] ext_en, ext_val, ev;
  int num_errors, cmp_count, seed;
  qbpb_core_model core (.*);
  qbpb_top uut (.*);
  // Pads: driver wins, then outside source, then pullup; port zero floats
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & {24'hFFFFFF, {8{flt}}});
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) flt <= ~flt;
  task give_verdict;
    $display("TB: checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] e, input logic [31:0] got);
    cmp_count++;
    if (got !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask
  // Read data stand only in the cycle after the strobe; judged mid-cycle
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys)
    if (rd_d)
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  // Two cycle marks guarantee a commit, then time for buffer and sync
  task settle;
    int n, m;
    n = 0;
    m = 0;
    while (m < 2 && n < 60)
    begin
      @(negedge clk_sys);
      m += int'(cycle_mark);
      n++;
    end
    if (m < 2)
    begin
      num_errors++;
      give_verdict;
    end
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Hang guard, far above the length of the run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    give_verdict;
  end
  initial
  begin
    seed = 32'had2c;
    {resetn, reg_wr, reg_rd, ext_access, ext_addr16, ext_low_drive, flt} = '0;
    {reg_addr, reg_wdata, muxed_low_bus_out, high_address_bus} = '0;
    {ext_en, ext_val} = '0;
    {timer_two_clock_out, array_module_out, serial_tx_out, write_strobe_n, read_strobe_n} = '1;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int p = 0; p < 4; p++)
      rd(ADDR_LATCH_BASE + 4'(p), LATCH_RESET);
    for (int p = 1; p < 4; p++)
      rd(ADDR_PIN_BASE + 4'(p), 8'hFF);
    rd(4'hC, 8'h00);
    $display("TB: reset test done");
    ev = $random(seed);
    ext_val <= ev;
    ext_en <= 32'h000000FF;
    for (int p = 0; p < 4; p++)
    begin
      v = 8'($random(seed));
      wr(ADDR_LATCH_BASE + 4'(p), v);
      settle;
      chk("pin_oe_n", v, pin_oe_n[8*p +: 8]);
      rd(ADDR_LATCH_BASE + 4'(p), v);
      rd(ADDR_PIN_BASE + 4'(p), (p == 0) ? (v & ev[7:0]) : v);
      b = 3'($random(seed));
      s = 1'($random(seed));
      wr(ADDR_LATCH_BASE + 4'(p), ~v);
      wr(ADDR_BIT_BASE + 4'(p), {4'h0, s, b});
      v = ~v;
      v[b] = s;
      settle;
      rd(ADDR_LATCH_BASE + 4'(p), v);
      wr(ADDR_LATCH_BASE + 4'(p), 8'hFF);
      settle;
    end
    $display("TB: latch test done");
    @(posedge clk_sys);
    ext_en <= 32'hFFFFFF00;
    repeat (4)
    begin
      ev = $random(seed);
      ext_val <= ev;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("port1 alt in", ev[15:8], {array_module_pin, array_external_clock,
        timer_two_reload_capture_in, timer_two_clock_io});
      chk("port3 alt in", {ev[29:26], ev[24]}, {timer_one_count_in, timer_zero_count_in,
        external_irq_one, external_irq_zero, serial_rx_in});
      chk("keeper_pullup", ev[31:8], keeper_pullup[31:8]);
      rd(ADDR_PIN_BASE + 4'h3, ev[31:24]);
    end
    ext_en <= '0;
    {serial_tx_out, write_strobe_n, read_strobe_n} <= 3'b000;
    {timer_two_clock_out, array_module_out} <= 6'h14;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("port3 oe_n", 8'h3D, pin_oe_n[31:24]);
    chk("port1 oe_n", 8'hA6, pin_oe_n[15:8]);
    {timer_two_clock_out, array_module_out, serial_tx_out, write_strobe_n, read_strobe_n} <= '1;
    $display("TB: alternate test done");
    // Port zero holds zeros so the forced ones are visible afterwards
    wr(ADDR_LATCH_BASE, 8'h00);
    settle;
    v = 8'($random(seed));
    wr(ADDR_LATCH_BASE + 4'h2, v);
    settle;
    @(posedge clk_sys);
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    muxed_low_bus_out <= lo;
    high_address_bus <= hi;
    // Short address first: port two keeps showing its own latch
    {ext_access, ext_addr16, ext_low_drive} <= 3'b101;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("port2 paging", v, pin_oe_n[23:16]);
    @(posedge clk_sys);
    ext_addr16 <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("port0 bus", {8'h00, lo}, {pin_oe_n[7:0], pin_out[7:0]});
    chk("port2 bus", {8'h00, hi}, {pin_oe_n[23:16], pin_out[23:16]});
    @(posedge clk_sys);
    ext_low_drive <= 1'b0;
    ext_en <= 32'h000000FF;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("muxed_low_bus_in", ev[7:0], muxed_low_bus_in);
    @(posedge clk_sys);
    {ext_access, ext_addr16} <= 2'b00;
    ext_en <= '0;
    settle;
    rd(ADDR_LATCH_BASE, 8'hFF);
    rd(ADDR_LATCH_BASE + 4'h2, v);
    @(negedge clk_sys);
    chk("port0 float", 8'hFF, pin_oe_n[7:0]);
    chk("port2 back", v, pin_oe_n[23:16]);
    repeat (2) @(posedge clk_sys);
    $display("TB: bus test done");
    give_verdict;
  end
endmodule
